// >>> logic/mbm_pkg.sv
// package: constants and types for the mailbox and bus-matching block
`default_nettype none
package mbm_pkg;
   // ***************************************************************
   // widths and depths
   // ***************************************************************
   localparam int DATA_W = 36;
   localparam int WORD_W = 18;
   localparam int BYTE_W = 9;
   localparam int FIFO_DEPTH = 16;
   // ***************************************************************
   // counts and reset values
   // ***************************************************************
   localparam logic [1:0] PART_FIRST = 2'h0;
   localparam logic [1:0] PART_SECOND = 2'h1;
   localparam logic [1:0] LAST_PART_LONG = 2'h0;
   localparam logic [1:0] LAST_PART_WORD = 2'h1;
   localparam logic [1:0] LAST_PART_BYTE = 2'h3;
   localparam logic FLAG_NO_MAIL = 1'h1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0_0000_0000;
   localparam logic [DATA_W-1:0] MASK_LONG = 36'hF_FFFF_FFFF;
   localparam logic [DATA_W-1:0] MASK_WORD = 36'h0_0003_FFFF;
   localparam logic [DATA_W-1:0] MASK_BYTE = 36'h0_0000_01FF;
   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {SZ_LONG, SZ_WORD, SZ_BYTE} mbm_size_t;
   typedef enum logic {CFG_IN_RESET, CFG_RUN} mbm_cfg_state_t;
   typedef struct packed {
      logic clock;
      logic cs_n;
      logic dir;
      logic en;
      logic mail;
      logic [DATA_W-1:0] data;
   } mbm_port_in_t;
   typedef struct packed {
      logic bus_match;
      logic size;
      logic byte_order;
      logic rst_n;
   } mbm_cfg_in_t;
endpackage
`default_nettype wire

// >>> logic/mbm_top.sv
// design: mailbox bypass registers and port B bus-matching reads
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// long-word queue
// ***************************************************************
module mbm_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic flush,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_q, rd_ptr_q;
   logic [PW:0] count_q;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // compare at the counter's own width; a pointer-wide cast of the depth would wrap to zero
   assign in_ready = (count_q != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count_q != '0);
   assign out_data = mem[rd_ptr_q];

   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_ptr_q] <= in_data;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else if (flush)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + PW'(1);
         if (pop)
            rd_ptr_q <= rd_ptr_q + PW'(1);
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // mbm_fifo

// ***************************************************************
// top
// ***************************************************************
module mbm_top
   import mbm_pkg::*;
(
   // system
   input wire logic sys_clk,
   input wire logic reset,
   // port A pins
   input wire logic port_a_clock,
   input wire logic port_a_chip_select_n,
   input wire logic port_a_direction,
   input wire logic port_a_enable,
   input wire logic port_a_mail_select,
   input wire logic [DATA_W-1:0] port_a_data_in,
   output logic [DATA_W-1:0] port_a_data_out,
   output logic port_a_data_oe,
   // port B pins
   input wire logic port_b_clock,
   input wire logic port_b_chip_select_n,
   input wire logic port_b_direction,
   input wire logic port_b_enable,
   input wire logic port_b_mail_select,
   input wire logic [DATA_W-1:0] port_b_data_in,
   output logic [DATA_W-1:0] port_b_data_out,
   output logic port_b_data_oe,
   // configuration and flags
   input wire logic master_reset_n,
   input wire logic bus_match_select,
   input wire logic size_select,
   input wire logic byte_order_select,
   output logic a_to_b_mail_flag_n,
   output logic b_to_a_mail_flag_n,
   output logic full_or_input_ready_flag,
   output logic output_ready_flag
);
   // ***************************************************************
   // functions
   // ***************************************************************
   function automatic logic [DATA_W-1:0] lane_mask(input mbm_size_t sz);
      case (sz)
         SZ_WORD: lane_mask = MASK_WORD;
         SZ_BYTE: lane_mask = MASK_BYTE;
         default: lane_mask = MASK_LONG;
      endcase
   endfunction

   // part idx of a long word, low lanes, unused lanes zero
   function automatic logic [DATA_W-1:0] pick_part(input logic [DATA_W-1:0] w,
      input mbm_size_t sz, input logic big, input logic [1:0] idx);
      logic [1:0] slot;
      slot = big ? ~idx : idx;
      case (sz)
         SZ_WORD: pick_part = slot[0] ? {18'h0_0000, w[35:18]} : {18'h0_0000, w[17:0]};
         SZ_BYTE: pick_part = {27'h000_0000, w[9*slot +: 9]};
         default: pick_part = w;
      endcase
   endfunction

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   mbm_port_in_t a_s1_q, a_s2_q, b_s1_q, b_s2_q;
   mbm_cfg_in_t cfg_s1_q, cfg_s2_q;
   logic a_clk_d1_q, b_clk_d1_q, rst_n_d1_q;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         // chip selects rest at their idle level so no data bus is driven after reset
         a_s1_q <= '{cs_n: 1'h1, default: '0};
         a_s2_q <= '{cs_n: 1'h1, default: '0};
         b_s1_q <= '{cs_n: 1'h1, default: '0};
         b_s2_q <= '{cs_n: 1'h1, default: '0};
         cfg_s1_q <= '0;
         cfg_s2_q <= '0;
         a_clk_d1_q <= 1'h0;
         b_clk_d1_q <= 1'h0;
         rst_n_d1_q <= 1'h0;
      end
      else
      begin
         a_s1_q <= '{port_a_clock, port_a_chip_select_n, port_a_direction,
                    port_a_enable, port_a_mail_select, port_a_data_in};
         b_s1_q <= '{port_b_clock, port_b_chip_select_n, port_b_direction,
                    port_b_enable, port_b_mail_select, port_b_data_in};
         cfg_s1_q <= '{bus_match_select, size_select, byte_order_select, master_reset_n};
         a_s2_q <= a_s1_q;
         b_s2_q <= b_s1_q;
         cfg_s2_q <= cfg_s1_q;
         a_clk_d1_q <= a_s2_q.clock;
         b_clk_d1_q <= b_s2_q.clock;
         rst_n_d1_q <= cfg_s2_q.rst_n;
      end
   end

   // ***************************************************************
   // strobes and configuration
   // ***************************************************************
   mbm_cfg_state_t cfg_state_q, cfg_state_d;
   mbm_size_t size_q;
   logic big_q;

   wire a_sel = a_s2_q.clock & ~a_clk_d1_q & ~a_s2_q.cs_n & a_s2_q.en;
   wire b_sel = b_s2_q.clock & ~b_clk_d1_q & ~b_s2_q.cs_n & b_s2_q.en;
   // port A writes with direction high, port B writes with direction low
   wire a_mail_wr = a_sel & a_s2_q.dir & a_s2_q.mail;
   wire a_mail_rd = a_sel & ~a_s2_q.dir & a_s2_q.mail;
   wire a_fifo_wr = a_sel & a_s2_q.dir & ~a_s2_q.mail;
   wire b_mail_wr = b_sel & ~b_s2_q.dir & b_s2_q.mail;
   wire b_mail_rd = b_sel & b_s2_q.dir & b_s2_q.mail;
   wire b_fifo_rd = b_sel & b_s2_q.dir & ~b_s2_q.mail;
   wire rst_rise = cfg_s2_q.rst_n & ~rst_n_d1_q;
   wire running = (cfg_state_q == CFG_RUN) & cfg_s2_q.rst_n;
   wire mbm_size_t size_pins = !cfg_s2_q.bus_match ? SZ_LONG :
                               (cfg_s2_q.size ? SZ_BYTE : SZ_WORD);
   wire [DATA_W-1:0] mask = lane_mask(size_q);
   wire [1:0] last_part = (size_q == SZ_BYTE) ? LAST_PART_BYTE :
                          (size_q == SZ_WORD) ? LAST_PART_WORD : LAST_PART_LONG;

   always_comb
   begin
      cfg_state_d = cfg_state_q;
      case (cfg_state_q)
         CFG_IN_RESET: if (rst_rise) cfg_state_d = CFG_RUN;
         CFG_RUN: if (!cfg_s2_q.rst_n) cfg_state_d = CFG_IN_RESET;
         default: cfg_state_d = CFG_IN_RESET;
      endcase
   end

   // sizes are sampled once so a pin that wanders later cannot tear a long word
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         cfg_state_q <= CFG_IN_RESET;
         size_q <= SZ_LONG;
         big_q <= 1'h0;
      end
      else
      begin
         cfg_state_q <= cfg_state_d;
         if (rst_rise)
         begin
            size_q <= size_pins;
            big_q <= cfg_s2_q.byte_order;
         end
      end
   end

   // ***************************************************************
   // mail registers
   // ***************************************************************
   logic [DATA_W-1:0] a_to_b_mail_q, b_to_a_mail_q;
   logic flag1_q, flag2_q;
   wire a_wr_ok = running & a_mail_wr & flag1_q;
   wire b_wr_ok = running & b_mail_wr & flag2_q;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         a_to_b_mail_q <= DATA_ZERO;
         b_to_a_mail_q <= DATA_ZERO;
      end
      else
      begin
         if (a_wr_ok)
            a_to_b_mail_q <= a_s2_q.data & mask;
         if (b_wr_ok)
            b_to_a_mail_q <= b_s2_q.data & mask;
      end
   end

   // a write in the same cycle as the far read wins only into an empty register; a write to a full one is dropped
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         flag1_q <= FLAG_NO_MAIL;
         flag2_q <= FLAG_NO_MAIL;
      end
      else if (!running)
      begin
         flag1_q <= FLAG_NO_MAIL;
         flag2_q <= FLAG_NO_MAIL;
      end
      else
      begin
         if (a_wr_ok)
            flag1_q <= 1'h0;
         else if (b_mail_rd)
            flag1_q <= FLAG_NO_MAIL;
         if (b_wr_ok)
            flag2_q <= 1'h0;
         else if (a_mail_rd)
            flag2_q <= FLAG_NO_MAIL;
      end
   end

   assign a_to_b_mail_flag_n = flag1_q;
   assign b_to_a_mail_flag_n = flag2_q;

   // ***************************************************************
   // long-word queue and bus matching
   // ***************************************************************
   logic fifo_in_ready, fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data, hold_q, out_q;
   logic [1:0] part_q;
   logic busy_q;
   wire b_read_ok = running & b_fifo_rd;
   wire fetch = b_read_ok & ~busy_q & fifo_out_valid;
   wire drain = b_read_ok & busy_q;
   wire drain_done = (part_q == last_part);

   // whole long words only; splitting happens on the drain side
   mbm_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .flush(~running),
      .in_valid(running & a_fifo_wr),
      .in_ready(fifo_in_ready),
      .in_data(a_s2_q.data),
      .out_valid(fifo_out_valid),
      .out_ready(fetch),
      .out_data(fifo_out_data)
   );

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         hold_q <= DATA_ZERO;
         out_q <= DATA_ZERO;
         part_q <= PART_FIRST;
         busy_q <= 1'h0;
      end
      else if (!running)
      begin
         part_q <= PART_FIRST;
         busy_q <= 1'h0;
      end
      else if (fetch)
      begin
         hold_q <= fifo_out_data;
         out_q <= pick_part(fifo_out_data, size_q, big_q, PART_FIRST);
         part_q <= PART_SECOND;
         busy_q <= (last_part != LAST_PART_LONG);
      end
      else if (drain)
      begin
         out_q <= pick_part(hold_q, size_q, big_q, part_q);
         part_q <= drain_done ? PART_FIRST : part_q + 2'h1;
         busy_q <= ~drain_done;
      end
   end

   assign full_or_input_ready_flag = running & fifo_in_ready;
   assign output_ready_flag = running & (busy_q | fifo_out_valid);

   // ***************************************************************
   // data outputs
   // ***************************************************************
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         port_a_data_out <= DATA_ZERO;
         port_b_data_out <= DATA_ZERO;
         port_a_data_oe <= 1'h0;
         port_b_data_oe <= 1'h0;
      end
      else
      begin
         // port A has no queue output, so its queue lanes read zero
         port_a_data_out <= a_s2_q.mail ? (b_to_a_mail_q & mask) : DATA_ZERO;
         port_b_data_out <= b_s2_q.mail ? (a_to_b_mail_q & mask) : out_q;
         port_a_data_oe <= ~a_s2_q.cs_n & ~a_s2_q.dir;
         port_b_data_oe <= ~b_s2_q.cs_n & b_s2_q.dir;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_fetch;
      fetch;
   endsequence
   sequence s_last_drain;
      drain && drain_done;
   endsequence

   a_a_to_b_mail_register_write: assert property (a_wr_ok |=> !a_to_b_mail_flag_n &&
      a_to_b_mail_q == ($past(a_s2_q.data) & mask)) else $error("a_to_b_mail_register write lost");
   a_a_to_b_mail_register_width: assert property (a_wr_ok |=> (a_to_b_mail_q & ~mask) == DATA_ZERO)
      else $error("a_to_b_mail_register kept upper lines");
   a_b_to_a_mail_register_write: assert property (b_wr_ok |=> !b_to_a_mail_flag_n &&
      (b_to_a_mail_q & ~mask) == DATA_ZERO) else $error("b_to_a_mail_register write wrong");
   a_mail_full_hold: assert property (running && a_mail_wr && !flag1_q |=>
      $stable(a_to_b_mail_q)) else $error("a_to_b_mail_register overwritten while full");
   a_mail_read_keep: assert property (a_mail_rd && !b_wr_ok |=> $stable(b_to_a_mail_q) &&
      b_to_a_mail_flag_n) else $error("b_to_a_mail_register read wrong");
   a_a_to_b_mail_register_read_flag: assert property (running && b_mail_rd && !a_wr_ok |=>
      a_to_b_mail_flag_n && $stable(a_to_b_mail_q)) else $error("a_to_b_mail_register flag not set");
   a_mail_out_mux: assert property (b_s2_q.mail |=>
      port_b_data_out == ($past(a_to_b_mail_q) & $past(mask))) else $error("mail B out wrong");
   a_reset_clear: assert property (!cfg_s2_q.rst_n |=> a_to_b_mail_flag_n &&
      b_to_a_mail_flag_n && part_q == PART_FIRST && !busy_q) else $error("reset state");
   a_order_latch: assert property (rst_rise |=> big_q == $past(cfg_s2_q.byte_order) &&
      cfg_state_q == CFG_RUN) else $error("byte order not latched");
   a_ready_gate: assert property (!running |-> !full_or_input_ready_flag)
      else $error("ready before config");
   a_long_pass: assert property (s_fetch and size_q == SZ_LONG |=>
      out_q == $past(fifo_out_data) && !busy_q) else $error("long word altered");
   a_word_first: assert property (s_fetch and size_q == SZ_WORD |=>
      out_q[17:0] == (big_q ? hold_q[35:18] : hold_q[17:0])) else $error("word order");
   a_byte_first: assert property (s_fetch and size_q == SZ_BYTE |=>
      out_q[8:0] == (big_q ? hold_q[35:27] : hold_q[8:0])) else $error("byte order");
   a_part_finish: assert property (s_last_drain |=> !busy_q &&
      part_q == PART_FIRST) else $error("part counter overrun");
endmodule // mbm_top
`default_nettype wire

// >>> verif/mbm_port_model.sv
// partner model: a synchronous bus host that works one port of the block
`timescale 1ns/1ps
`default_nettype none

module mbm_port_model
   import mbm_pkg::*;
(
   // system clock
   input wire logic sys_clk,
   // pins towards the block
   output logic port_clock,
   output logic chip_select_n,
   output logic direction,
   output logic enable,
   output logic mail_select,
   output logic [DATA_W-1:0] data_to_block,
   // pins from the block
   input wire logic [DATA_W-1:0] data_from_block,
   input wire logic data_oe
);
   // port clock stands still between transfers
   initial
   begin
      port_clock = 1'h0;
      chip_select_n = 1'h1;
      direction = 1'h0;
      enable = 1'h0;
      mail_select = 1'h0;
      data_to_block = DATA_ZERO;
   end

   // ***************************************************************
   // one strobe: set-up, rise, fall, sample, release
   // ***************************************************************
   // pins are sampled by the block, so set-up, rise and fall each last 3 system clocks
   task automatic strobe(input logic dir, input logic mail, input logic [DATA_W-1:0] wdata,
                         output logic [DATA_W-1:0] rdata, output logic rdata_oe);
      @(posedge sys_clk);
      chip_select_n <= 1'h0;
      direction <= dir;
      enable <= 1'h1;
      mail_select <= mail;
      data_to_block <= wdata;
      repeat (3) @(posedge sys_clk);
      port_clock <= 1'h1;
      repeat (3) @(posedge sys_clk);
      port_clock <= 1'h0;
      repeat (3) @(posedge sys_clk);
      rdata = data_from_block;
      rdata_oe = data_oe;
      chip_select_n <= 1'h1;
      enable <= 1'h0;
      // released lines show the inverse, never a stale copy
      data_to_block <= ~wdata;
   endtask
endmodule // mbm_port_model
`default_nettype wire

// >>> verif/testbench.sv
// testbench: mailbox transfers, bus-matching reads and queue fill
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import mbm_pkg::*;
   typedef struct {
      logic bm;
      logic sz;
      logic be;
      int parts;
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] exp [4];
   } mbm_row_t;
   localparam logic [8:0] LA = 9'h0A1;
   localparam logic [8:0] LB = 9'h0B2;
   localparam logic [8:0] LC = 9'h0C3;
   localparam logic [8:0] LD = 9'h0D4;
   localparam logic [DATA_W-1:0] WORD = {LA, LB, LC, LD};
   localparam logic [DATA_W-1:0] MAIL_A = 36'hF_5A5A_5A5A;
   localparam logic [DATA_W-1:0] MAIL_B = 36'hA_A5A5_A5A5;
   localparam logic [DATA_W-1:0] Z = DATA_ZERO;
   logic sys_clk = 1'h0;
   logic reset = 1'h1;
   logic master_reset_n = 1'h0;
   logic bus_match_select = 1'h0;
   logic size_select = 1'h0;
   logic byte_order_select = 1'h0;
   logic pa_clk, pa_cs_n, pa_dir, pa_en, pa_mail, pa_oe, pb_clk, pb_cs_n, pb_dir, pb_en, pb_mail, pb_oe;
   logic [DATA_W-1:0] pa_in, pa_out, pb_in, pb_out, q;
   logic a_to_b_mail_flag_n, b_to_a_mail_flag_n, full_or_input_ready_flag, output_ready_flag, oe;
   int error_cnt = 0;
   int checks_done = 0;
   int n;
   mbm_row_t rows [6] = '{
      '{1'h0, 1'h0, 1'h1, 1, MASK_LONG, '{WORD, Z, Z, Z}},
      '{1'h0, 1'h0, 1'h0, 1, MASK_LONG, '{WORD, Z, Z, Z}},
      '{1'h1, 1'h0, 1'h1, 2, MASK_WORD, '{{18'h0, LA, LB}, {18'h0, LC, LD}, Z, Z}},
      '{1'h1, 1'h0, 1'h0, 2, MASK_WORD, '{{18'h0, LC, LD}, {18'h0, LA, LB}, Z, Z}},
      '{1'h1, 1'h1, 1'h1, 4, MASK_BYTE, '{{27'h0, LA}, {27'h0, LB}, {27'h0, LC}, {27'h0, LD}}},
      '{1'h1, 1'h1, 1'h0, 4, MASK_BYTE, '{{27'h0, LD}, {27'h0, LC}, {27'h0, LB}, {27'h0, LA}}}};

   always #5 sys_clk = ~sys_clk;

   mbm_top mbm_top_i (.sys_clk(sys_clk), .reset(reset), .port_a_clock(pa_clk), .port_a_chip_select_n(pa_cs_n),
      .port_a_direction(pa_dir), .port_a_enable(pa_en), .port_a_mail_select(pa_mail), .port_a_data_in(pa_in),
      .port_a_data_out(pa_out), .port_a_data_oe(pa_oe), .port_b_clock(pb_clk), .port_b_chip_select_n(pb_cs_n),
      .port_b_direction(pb_dir), .port_b_enable(pb_en), .port_b_mail_select(pb_mail), .port_b_data_in(pb_in),
      .port_b_data_out(pb_out), .port_b_data_oe(pb_oe), .master_reset_n(master_reset_n),
      .bus_match_select(bus_match_select), .size_select(size_select), .byte_order_select(byte_order_select),
      .a_to_b_mail_flag_n(a_to_b_mail_flag_n), .b_to_a_mail_flag_n(b_to_a_mail_flag_n),
      .full_or_input_ready_flag(full_or_input_ready_flag), .output_ready_flag(output_ready_flag));
   mbm_port_model port_a_i (.sys_clk(sys_clk), .port_clock(pa_clk), .chip_select_n(pa_cs_n), .direction(pa_dir),
      .enable(pa_en), .mail_select(pa_mail), .data_to_block(pa_in), .data_from_block(pa_out), .data_oe(pa_oe));
   mbm_port_model port_b_i (.sys_clk(sys_clk), .port_clock(pb_clk), .chip_select_n(pb_cs_n), .direction(pb_dir),
      .enable(pb_en), .mail_select(pb_mail), .data_to_block(pb_in), .data_from_block(pb_out), .data_oe(pb_oe));

   // ***************************************************************
   // compare, configuration and closing tasks
   // ***************************************************************
   task automatic check_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
      end
   endtask

   task automatic mreset(input logic bm, input logic sz, input logic be);
      int k = 0;
      @(posedge sys_clk);
      master_reset_n <= 1'h0;
      bus_match_select <= bm;
      size_select <= sz;
      byte_order_select <= be;
      repeat (6) @(posedge sys_clk);
      check_bit(a_to_b_mail_flag_n, 1'h1);
      check_bit(full_or_input_ready_flag, 1'h0);
      master_reset_n <= 1'h1;
      while (full_or_input_ready_flag !== 1'h1 && k < 20)
      begin
         @(posedge sys_clk);
         k++;
      end
      check_bit(full_or_input_ready_flag, 1'h1);
   endtask

   task automatic results();
      $display("errors %0d, checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      $display("unexpected at %0t: run did not finish in time", $time);
      results();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'h0;
      repeat (2) @(posedge sys_clk);
      check_bit(pa_oe, 1'h0);
      repeat (2) @(posedge sys_clk);
      check_bit(b_to_a_mail_flag_n, 1'h1);
      for (int r = 0; r < 6; r++)
      begin
         mreset(rows[r].bm, rows[r].sz, rows[r].be);
         port_a_i.strobe(1'h1, 1'h1, MAIL_A, q, oe);
         check_bit(a_to_b_mail_flag_n, 1'h0);
         port_a_i.strobe(1'h1, 1'h1, ~MAIL_A, q, oe);
         port_b_i.strobe(1'h1, 1'h1, Z, q, oe);
         check_data(q, MAIL_A & rows[r].mask);
         check_bit(oe, 1'h1);
         check_bit(a_to_b_mail_flag_n, 1'h1);
         port_b_i.strobe(1'h1, 1'h1, Z, q, oe);
         check_data(q, MAIL_A & rows[r].mask);
         port_b_i.strobe(1'h0, 1'h1, MAIL_B, q, oe);
         check_bit(b_to_a_mail_flag_n, 1'h0);
         check_bit(oe, 1'h0);
         port_a_i.strobe(1'h0, 1'h1, Z, q, oe);
         check_data(q, MAIL_B & rows[r].mask);
         check_bit(b_to_a_mail_flag_n, 1'h1);
         check_bit(oe, 1'h1);
         port_a_i.strobe(1'h1, 1'h0, WORD, q, oe);
         for (int p = 0; p < rows[r].parts; p++)
         begin
            port_b_i.strobe(1'h1, 1'h0, Z, q, oe);
            check_data(q, rows[r].exp[p]);
         end
         check_bit(output_ready_flag, 1'h0);
      end
      // master reset in mid long word, with mail waiting and the order pin moved later
      port_a_i.strobe(1'h1, 1'h0, WORD, q, oe);
      port_b_i.strobe(1'h1, 1'h0, Z, q, oe);
      check_data(q, {27'h0, LD});
      port_a_i.strobe(1'h1, 1'h1, MAIL_A, q, oe);
      mreset(1'h1, 1'h1, 1'h0);
      byte_order_select <= 1'h1;
      port_a_i.strobe(1'h1, 1'h0, ~WORD, q, oe);
      port_b_i.strobe(1'h1, 1'h0, Z, q, oe);
      check_data(q, {27'h0, ~LD});
      // fill the queue while port B stalls, then drain it
      mreset(1'h0, 1'h0, 1'h0);
      n = 0;
      while (full_or_input_ready_flag === 1'h1 && n < 40)
      begin
         port_a_i.strobe(1'h1, 1'h0, WORD ^ 36'(n), q, oe);
         n++;
      end
      check_bit(n == FIFO_DEPTH, 1'h1);
      port_a_i.strobe(1'h1, 1'h0, Z, q, oe);
      for (int i = 0; i < n; i++)
      begin
         port_b_i.strobe(1'h1, 1'h0, Z, q, oe);
         check_data(q, WORD ^ 36'(i));
      end
      check_bit(output_ready_flag, 1'h0);
      results();
   end
endmodule // testbench
`default_nettype wire
